// ==== hw/rtc_pkg.sv ====
// Shared constants and types for the serial clock/RAM access supervisor
package rtc_pkg;
  localparam logic [6:0] SLAVE_ADDR  = 7'h68;
  localparam int         MEM_DEPTH   = 160;
  localparam logic [7:0] LAST_ADDR   = 8'h9F;
  localparam logic [7:0] CLOCK_LAST  = 8'h07;
  localparam logic [7:0] FLAG_ADDR   = 8'h0F;
  localparam logic [7:0] TAMP1_ADDR  = 8'h14;
  localparam logic [7:0] TAMP2_ADDR  = 8'h15;
  localparam int         TEB_BIT     = 7;
  localparam int         TCM_BIT     = 6;
  localparam int         TPM_BIT     = 5;
  localparam int         TB1_BIT     = 0;
  localparam int         TB2_BIT     = 1;
  localparam int         CLOCK_BYTES = 8;
  localparam logic [3:0] BIT_LAST    = 4'h8;
  localparam logic [3:0] BIT_OUT_END = 4'h7;
  localparam logic [3:0] ACK_SEEN    = 4'h1;
  // APB register map
  localparam int         APB_AW      = 8;
  localparam logic [7:0] OFF_STATUS  = 8'h00;
  localparam logic [7:0] OFF_MASK    = 8'h04;
  localparam logic [7:0] OFF_STATE   = 8'h08;
  localparam int         IRQ_W       = 4;
  localparam int         IRQ_TAMP1   = 0;
  localparam int         IRQ_TAMP2   = 1;
  localparam int         IRQ_PFAIL   = 2;
  localparam int         IRQ_WRITE   = 3;
  localparam int         ST_PTR      = 0;
  localparam int         ST_PF       = 8;
  localparam int         ST_BO       = 9;
  localparam int         ST_RC       = 10;
  localparam int         ST_FRZ      = 11;
  localparam int         ST_TB1      = 12;
  localparam int         ST_TB2      = 13;
  typedef enum logic [8:0] {
    S_IDLE      = 9'h001,
    S_ADDR      = 9'h002,
    S_ADDR_ACK  = 9'h004,
    S_WADDR     = 9'h008,
    S_WADDR_ACK = 9'h010,
    S_WDATA     = 9'h020,
    S_WDATA_ACK = 9'h040,
    S_RDATA     = 9'h080,
    S_RDATA_ACK = 9'h100
  } state_e;
endpackage

// ==== hw/tamper_detect.sv ====
// One tamper input: synchroniser, mode decode and sticky flag
`timescale 1ns/1ps
module tamper_detect (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic pinRaw,
  input  wire logic enable,
  input  wire logic connectMode,
  input  wire logic polarityMode,
  output logic      flag,
  output logic      hit
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic flag;
    logic hit;
  } td_s;

  td_s  td_reg;
  td_s  td_next;
  logic tamper;

  // Normally open: pin pulled to the polarity level; normally closed: pin leaves it
  assign tamper = connectMode ? (td_reg.s2 == polarityMode)
                              : (td_reg.s2 != polarityMode);

  always_comb begin
    td_next      = td_reg;
    td_next.s1   = pinRaw;
    td_next.s2   = td_reg.s1;
    td_next.hit  = enable & tamper & ~td_reg.flag;
    // Flag is cleared only by dropping the enable
    td_next.flag = enable & (td_reg.flag | tamper);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      td_reg <= '0;
    end else begin
      td_reg <= td_next;
    end
  end

  assign flag = td_reg.flag;
  assign hit  = td_reg.hit;

  a_flag_set: assert property (@(posedge clk_sys) disable iff (rst)
    enable && tamper |=> flag && $past(enable))
    else $error("tamper flag not set");
endmodule

// ==== hw/serial_rtc_access_supervisor.sv ====
// Serial slave access, clock freeze, power-fail protection and tamper flags
//
// What this block does
// - Answer only slave address D0h with direction bit, after a START.
// - Random read: write slave address, then word address loads the pointer.
// - Repeated START with read direction sends the byte at the pointer.
// - Pointer steps only on an acknowledge clock.
// - Reading continues while master acknowledges; STOP ends the transfer.
// - Accessing clock addresses freezes copying of live time into user bytes.
// - Read without word address starts at the pointer last held.
// - Write: slave address, word address into pointer, then data bytes.
// - Each written byte is stored at pointer, pointer steps on ack clock.
// - Acknowledge slave address, word address and every written data byte.
// - Power fail aborts access, clears pointer, ignores bus inputs.
// - During power fail clock registers cannot be accessed or written.
// - Reset output asserted from power fail until the recovery interval ends.
// - External SRAM chip enable forced high during power fail.
// - On battery switchover all outputs go high impedance.
// - Recovery interval keeps write protection, chip enable inhibit and reset.
// - Enabled tamper input sets its flag in the flag byte.
// - Connect mode and polarity bits choose which pin state is a tamper.
`timescale 1ns/1ps
module serial_rtc_access_supervisor (
  input  wire logic                       clk_sys,
  input  wire logic                       rst,
  input  wire logic [rtc_pkg::APB_AW-1:0] paddr,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  output logic                            irq,
  input  wire logic                       sclIn,
  input  wire logic                       sdaIn,
  output logic                            sdaOut,
  output logic                            sdaOe,
  input  wire logic                       tamperInputOne,
  input  wire logic                       tamperInputTwo,
  input  wire logic                       powerFailIn,
  input  wire logic                       batterySwitchIn,
  input  wire logic                       recoveryIn,
  input  wire logic [63:0]                liveTime,
  input  wire logic                       liveUpdate,
  input  wire logic                       extChipEnInN,
  output logic                            extSramChipEnableN,
  output logic                            extSramOe,
  output logic                            rstOutN,
  output logic                            rstOutOe
);
  import rtc_pkg::*;

  typedef struct packed {
    logic                          sclS1, sclS2, sclS3;
    logic                          sdaS1, sdaS2, sdaS3;
    logic                          pfS1, pfS2, pfS3;
    logic                          boS1, boS2, rcS1, rcS2, ceS1, ceS2;
    state_e                        state;
    logic [3:0]                    bitCnt;
    logic [7:0]                    shreg;
    logic [7:0]                    ptr;
    logic                          rw;
    logic                          sdaOe;
    logic                          sdaOut;
    logic [MEM_DEPTH-1:0][7:0]     mem;
    logic [IRQ_W-1:0]              status;
    logic [IRQ_W-1:0]              mask;
    logic                          irq;
    logic [31:0]                   prdata;
    logic                          pready;
    logic                          pslverr;
    logic                          extCeN, extOe, rstN, rstOe;
  } st_s;

  st_s        st_reg;
  st_s        st_next;
  logic       sclRise, sclFall, startCond, stopCond;
  logic       pfNow, busOff, protect, freeze;
  logic       tb1, tb2, hit1, hit2;
  logic [7:0] rb;

  function automatic logic [7:0] incPtr(input logic [7:0] p);
    return (p >= LAST_ADDR) ? 8'h00 : p + 8'h01;
  endfunction

  function automatic logic isClock(input logic [7:0] p);
    return p <= CLOCK_LAST;
  endfunction

  // Flag byte shows live tamper flags; bytes beyond the map read as zero
  function automatic logic [7:0] rdByte(input st_s s, input logic f1, input logic f2);
    logic [7:0] b;
    b = '0;
    if (s.ptr <= LAST_ADDR) begin
      b = s.mem[s.ptr];
    end
    if (s.ptr == FLAG_ADDR) begin
      b[TB1_BIT] = f1;
      b[TB2_BIT] = f2;
    end
    return b;
  endfunction

  // Edges come from the second and third stages only
  assign sclRise   = st_reg.sclS2 & ~st_reg.sclS3;
  assign sclFall   = ~st_reg.sclS2 & st_reg.sclS3;
  assign startCond = st_reg.sclS2 & st_reg.sclS3 & st_reg.sdaS3 & ~st_reg.sdaS2;
  assign stopCond  = st_reg.sclS2 & st_reg.sclS3 & ~st_reg.sdaS3 & st_reg.sdaS2;
  assign pfNow     = st_reg.pfS2;
  assign busOff    = pfNow | st_reg.boS2;
  assign protect   = busOff | st_reg.rcS2;
  assign freeze    = (st_reg.state != S_IDLE) && (st_reg.state != S_ADDR)
                     && isClock(st_reg.ptr);
  assign rb        = rdByte(st_reg, tb1, tb2);

  tamper_detect u_tamper1 (
    .clk_sys      (clk_sys),
    .rst          (rst),
    .pinRaw       (tamperInputOne),
    .enable       (st_reg.mem[TAMP1_ADDR][TEB_BIT]),
    .connectMode  (st_reg.mem[TAMP1_ADDR][TCM_BIT]),
    .polarityMode (st_reg.mem[TAMP1_ADDR][TPM_BIT]),
    .flag         (tb1),
    .hit          (hit1)
  );

  tamper_detect u_tamper2 (
    .clk_sys      (clk_sys),
    .rst          (rst),
    .pinRaw       (tamperInputTwo),
    .enable       (st_reg.mem[TAMP2_ADDR][TEB_BIT]),
    .connectMode  (st_reg.mem[TAMP2_ADDR][TCM_BIT]),
    .polarityMode (st_reg.mem[TAMP2_ADDR][TPM_BIT]),
    .flag         (tb2),
    .hit          (hit2)
  );

  always_comb begin
    logic [IRQ_W-1:0] ev;
    logic [IRQ_W-1:0] clr;
    ev         = '0;
    clr        = '0;
    st_next    = st_reg;
    st_next.sclS1 = sclIn;
    st_next.sclS2 = st_reg.sclS1;
    st_next.sclS3 = st_reg.sclS2;
    st_next.sdaS1 = sdaIn;
    st_next.sdaS2 = st_reg.sdaS1;
    st_next.sdaS3 = st_reg.sdaS2;
    st_next.pfS1  = powerFailIn;
    st_next.pfS2  = st_reg.pfS1;
    st_next.pfS3  = st_reg.pfS2;
    st_next.boS1  = batterySwitchIn;
    st_next.boS2  = st_reg.boS1;
    st_next.rcS1  = recoveryIn;
    st_next.rcS2  = st_reg.rcS1;
    st_next.ceS1  = extChipEnInN;
    st_next.ceS2  = st_reg.ceS1;

    // Live time lands in the user bytes only while no clock byte is in use
    if (liveUpdate && !freeze) begin
      for (int i = 0; i < CLOCK_BYTES; i++) begin
        st_next.mem[i] = liveTime[8*i +: 8];
      end
    end

    if (busOff) begin
      // Bus inputs are ignored entirely while supply is out of tolerance
      st_next.state  = S_IDLE;
      st_next.sdaOe  = 1'b0;
      st_next.bitCnt = '0;
      if (pfNow) begin
        st_next.ptr = '0;
      end
    end else if (startCond) begin
      st_next.state  = S_ADDR;
      st_next.bitCnt = '0;
      st_next.sdaOe  = 1'b0;
    end else if (stopCond) begin
      st_next.state = S_IDLE;
      st_next.sdaOe = 1'b0;
    end else begin
      case (st_reg.state)
        S_ADDR, S_WADDR, S_WDATA: begin
          if (sclRise && st_reg.bitCnt != BIT_LAST) begin
            st_next.shreg  = {st_reg.shreg[6:0], st_reg.sdaS2};
            st_next.bitCnt = st_reg.bitCnt + 4'h1;
          end else if (sclFall && st_reg.bitCnt == BIT_LAST) begin
            st_next.bitCnt = '0;
            st_next.sdaOe  = 1'b1;
            if (st_reg.state == S_ADDR) begin
              if (st_reg.shreg[7:1] == SLAVE_ADDR) begin
                st_next.rw    = st_reg.shreg[0];
                st_next.state = S_ADDR_ACK;
              end else begin
                st_next.sdaOe = 1'b0;
                st_next.state = S_IDLE;
              end
            end else if (st_reg.state == S_WADDR) begin
              st_next.ptr   = st_reg.shreg;
              st_next.state = S_WADDR_ACK;
            end else begin
              st_next.state = S_WDATA_ACK;
            end
          end
        end
        S_ADDR_ACK: begin
          if (sclFall) begin
            if (st_reg.rw) begin
              // No word address needed: the held pointer is used as is
              st_next.shreg = rb;
              st_next.sdaOe = ~rb[7];
              st_next.state = S_RDATA;
            end else begin
              st_next.sdaOe = 1'b0;
              st_next.state = S_WADDR;
            end
          end
        end
        S_WADDR_ACK: begin
          if (sclFall) begin
            st_next.sdaOe = 1'b0;
            st_next.state = S_WDATA;
          end
        end
        S_WDATA_ACK: begin
          if (sclRise) begin
            if (st_reg.ptr <= LAST_ADDR && !(protect && isClock(st_reg.ptr))) begin
              st_next.mem[st_reg.ptr] = st_reg.shreg;
            end
            st_next.ptr     = incPtr(st_reg.ptr);
            ev[IRQ_WRITE]   = 1'b1;
          end else if (sclFall) begin
            st_next.sdaOe = 1'b0;
            st_next.state = S_WDATA;
          end
        end
        S_RDATA: begin
          if (sclFall) begin
            if (st_reg.bitCnt == BIT_OUT_END) begin
              st_next.bitCnt = '0;
              st_next.sdaOe  = 1'b0;
              st_next.state  = S_RDATA_ACK;
            end else begin
              st_next.bitCnt = st_reg.bitCnt + 4'h1;
              st_next.shreg  = {st_reg.shreg[6:0], 1'b0};
              st_next.sdaOe  = ~st_reg.shreg[6];
            end
          end
        end
        S_RDATA_ACK: begin
          if (sclRise) begin
            if (!st_reg.sdaS2) begin
              st_next.ptr    = incPtr(st_reg.ptr);
              st_next.bitCnt = ACK_SEEN;
            end else begin
              st_next.state = S_IDLE;
            end
          end else if (sclFall && st_reg.bitCnt == ACK_SEEN) begin
            st_next.bitCnt = '0;
            st_next.shreg  = rb;
            st_next.sdaOe  = ~rb[7];
            st_next.state  = S_RDATA;
          end
        end
        S_IDLE: begin
          st_next.sdaOe = 1'b0;
        end
        default: begin
          st_next.state = S_IDLE;
          st_next.sdaOe = 1'b0;
        end
      endcase
    end

    // All pins float once running from the battery
    if (st_reg.boS2) begin
      st_next.sdaOe = 1'b0;
    end
    st_next.rstN   = ~protect;
    st_next.extCeN = protect | st_reg.ceS2;
    st_next.extOe  = ~st_reg.boS2;
    st_next.rstOe  = ~st_reg.boS2;

    // APB slave: data prepared in setup, one access cycle with pready high
    ev[IRQ_TAMP1]   = hit1;
    ev[IRQ_TAMP2]   = hit2;
    ev[IRQ_PFAIL]   = st_reg.pfS2 & ~st_reg.pfS3;
    st_next.pready  = 1'b0;
    st_next.pslverr = 1'b0;
    if (psel && !penable) begin
      st_next.pready = 1'b1;
      st_next.prdata = '0;
      case (paddr)
        OFF_STATUS: begin
          st_next.prdata[IRQ_W-1:0] = st_reg.status;
        end
        OFF_MASK: begin
          st_next.prdata[IRQ_W-1:0] = st_reg.mask;
        end
        OFF_STATE: begin
          st_next.prdata[ST_PTR +: 8] = st_reg.ptr;
          st_next.prdata[ST_PF]       = pfNow;
          st_next.prdata[ST_BO]       = st_reg.boS2;
          st_next.prdata[ST_RC]       = st_reg.rcS2;
          st_next.prdata[ST_FRZ]      = freeze;
          st_next.prdata[ST_TB1]      = tb1;
          st_next.prdata[ST_TB2]      = tb2;
        end
        default: begin
          st_next.pslverr = 1'b1;
        end
      endcase
    end
    if (psel && penable && st_reg.pready && pwrite) begin
      if (paddr == OFF_STATUS) begin
        clr = pwdata[IRQ_W-1:0];
      end
      if (paddr == OFF_MASK) begin
        st_next.mask = pwdata[IRQ_W-1:0];
      end
    end
    // A new event in the clearing cycle stays set
    st_next.status = (st_reg.status & ~clr) | ev;
    st_next.irq    = |(st_reg.status & st_reg.mask);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_reg        <= '0;
      st_reg.state  <= S_IDLE;
      st_reg.sclS1  <= 1'b1;
      st_reg.sclS2  <= 1'b1;
      st_reg.sclS3  <= 1'b1;
      st_reg.sdaS1  <= 1'b1;
      st_reg.sdaS2  <= 1'b1;
      st_reg.sdaS3  <= 1'b1;
      st_reg.ceS1   <= 1'b1;
      st_reg.ceS2   <= 1'b1;
      st_reg.extCeN <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign prdata             = st_reg.prdata;
  assign pready             = st_reg.pready;
  assign pslverr            = st_reg.pslverr;
  assign irq                = st_reg.irq;
  assign sdaOut             = st_reg.sdaOut;
  assign sdaOe              = st_reg.sdaOe;
  assign extSramChipEnableN = st_reg.extCeN;
  assign extSramOe          = st_reg.extOe;
  assign rstOutN            = st_reg.rstN;
  assign rstOutOe           = st_reg.rstOe;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence quietBus;
    !busOff && !startCond && !stopCond;
  endsequence

  sequence addrMatch;
    quietBus and (st_reg.state == S_ADDR && sclFall && st_reg.bitCnt == BIT_LAST
                  && st_reg.shreg[7:1] == SLAVE_ADDR);
  endsequence

  sequence wdataAck;
    quietBus and (st_reg.state == S_WDATA_ACK && sclRise && st_reg.ptr <= LAST_ADDR
                  && !protect);
  endsequence

  a_addr_ack: assert property (addrMatch |=> st_reg.state == S_ADDR_ACK && sdaOe)
    else $error("own address not acknowledged");
  a_ptr_load: assert property (quietBus and (st_reg.state == S_WADDR && sclFall
    && st_reg.bitCnt == BIT_LAST) |=> st_reg.ptr == $past(st_reg.shreg))
    else $error("word address not loaded");
  a_read_first: assert property (quietBus and (st_reg.state == S_ADDR_ACK && st_reg.rw
    && sclFall) |=> st_reg.state == S_RDATA && st_reg.shreg == $past(rb))
    else $error("first read byte wrong");
  a_ptr_step: assert property (!$stable(st_reg.ptr) |-> $past(pfNow || sclFall
    || (sclRise && (st_reg.state == S_RDATA_ACK || st_reg.state == S_WDATA_ACK))))
    else $error("pointer moved off the ack clock");
  a_nack_end: assert property (quietBus and (st_reg.state == S_RDATA_ACK && sclRise
    && st_reg.sdaS2) |=> st_reg.state == S_IDLE)
    else $error("read continued after nack");
  a_freeze_hold: assert property (freeze && liveUpdate && st_reg.state != S_WDATA_ACK
    |=> $stable(st_reg.mem[0]))
    else $error("clock byte copied while frozen");
  a_store_byte: assert property (wdataAck |=> st_reg.mem[$past(st_reg.ptr)]
    == $past(st_reg.shreg) && st_reg.ptr == incPtr($past(st_reg.ptr)))
    else $error("write byte not stored");
  a_pf_abort: assert property (pfNow |=> st_reg.state == S_IDLE && st_reg.ptr == 8'h00
    && !sdaOe)
    else $error("power fail did not abort");
  a_prot_out: assert property (protect |=> !rstOutN && extSramChipEnableN)
    else $error("protection outputs not asserted");
  a_ce_high: assert property (protect |=> extSramChipEnableN)
    else $error("chip enable not inhibited");
  a_hiz_out: assert property (st_reg.boS2 |=> !extSramOe && !rstOutOe && !sdaOe)
    else $error("outputs driven on battery");
endmodule

// ==== tb/i2c_master_model.sv ====
// Behavioural I2C bus master driving SCL and pulling the open-drain SDA low
`timescale 1ns/1ps
module i2c_master_model (
  input  wire logic clk_sys,
  input  wire logic sda,
  output logic      scl,
  output logic      sdaPull
);
  initial begin
    scl = 1'b1;
    sdaPull = 1'b0;
  end
  // One quarter of the 160 ns SCL period; SCL stands high between frames
  task automatic quarter();
    repeat (4) @(posedge clk_sys);
  endtask
  // Also serves as repeated START: SDA is released before SCL rises
  task automatic start();
    sdaPull <= 1'b0;
    quarter();
    scl <= 1'b1;
    quarter();
    sdaPull <= 1'b1;
    quarter();
    scl <= 1'b0;
    quarter();
  endtask
  task automatic bitIo(input logic b, output logic r);
    sdaPull <= ~b;
    quarter();
    scl <= 1'b1;
    quarter();
    r = sda;
    quarter();
    scl <= 1'b0;
    quarter();
  endtask
  task automatic sendByte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitIo(d[i], r);
    bitIo(1'b1, r);
    ack = ~r;
  endtask
  task automatic recvByte(input logic ackIt, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bitIo(1'b1, d[i]);
    bitIo(~ackIt, r);
  endtask
  task automatic stop();
    sdaPull <= 1'b1;
    quarter();
    scl <= 1'b1;
    quarter();
    sdaPull <= 1'b0;
    quarter();
  endtask
endmodule

// ==== tb/test_serial_rtc_access_supervisor.sv ====
// Self-checking bench for the serial clock/RAM access supervisor
`timescale 1ns/1ps
module test_serial_rtc_access_supervisor;
  import rtc_pkg::*;
  logic        clk_sys, rst, psel, penable, pwrite, pready, pslverr, irq, scl, mPull, sdaOut;
  logic        sdaOe, tamperInputOne, tamperInputTwo, powerFailIn, batterySwitchIn, recoveryIn;
  logic        liveUpdate, extChipEnInN, extSramChipEnableN, extSramOe, rstOutN, rstOutOe;
  logic        lastErr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [63:0] liveTime;
  logic [3:0]  pwr;
  wire         sda;
  int          nMismatch = 0;
  int          nTests = 0;
  // Pull-up wire: low while either party pulls
  assign sda = (mPull || (sdaOe && !sdaOut)) ? 1'b0 : 1'b1;
  assign pwr = {extSramChipEnableN, extSramOe, rstOutN, rstOutOe};
  serial_rtc_access_supervisor u_dut (.clk_sys(clk_sys), .rst(rst), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .sclIn(scl), .sdaIn(sda),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .tamperInputOne(tamperInputOne),
    .tamperInputTwo(tamperInputTwo), .powerFailIn(powerFailIn),
    .batterySwitchIn(batterySwitchIn), .recoveryIn(recoveryIn), .liveTime(liveTime),
    .liveUpdate(liveUpdate), .extChipEnInN(extChipEnInN),
    .extSramChipEnableN(extSramChipEnableN), .extSramOe(extSramOe), .rstOutN(rstOutN),
    .rstOutOe(rstOutOe));
  i2c_master_model u_master (.clk_sys(clk_sys), .sda(sda), .scl(scl), .sdaPull(mPull));
  task automatic tally_and_finish();
    if (nMismatch == 0 && nTests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      nMismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    // Keeps psel from being assigned twice in one time step
    if (psel) @(posedge clk_sys);
    psel    <= 1'b1;
    paddr   <= a;
    pwrite  <= wr;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // No wait count is assumed here; only the watchdog ends a hung access
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    q = prdata;
    lastErr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    apb(1'b0, a, 32'h0000_0000, q);
    check(q, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask
  task automatic st(output logic [31:0] q);
    apb(1'b0, OFF_STATE, 32'h0000_0000, q);
  endtask
  task automatic iw(input logic [7:0] b, input logic expAck);
    logic a;
    u_master.sendByte(b, a);
    check(32'(a), 32'(expAck));
  endtask
  task automatic ir(input logic ackIt, input logic [7:0] exp);
    logic [7:0] d;
    u_master.recvByte(ackIt, d);
    check(32'(d), 32'(exp));
  endtask
  task automatic point(input logic [7:0] a);
    u_master.start();
    iw(8'hD0, 1'b1);
    iw(a, 1'b1);
  endtask
  task automatic rdAt(input logic [7:0] a, input logic [7:0] exp);
    point(a);
    u_master.start();
    iw(8'hD1, 1'b1);
    ir(1'b0, exp);
    u_master.stop();
  endtask
  task automatic settle();
    repeat (12) @(posedge clk_sys);
  endtask
  task automatic pulse();
    liveUpdate <= 1'b1;
    @(posedge clk_sys);
    liveUpdate <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic pin(input int k, input logic v);
    if (k == 0) tamperInputOne <= v;
    else tamperInputTwo <= v;
  endtask
  task automatic t_regs();
    check(32'(sdaOut), 32'h0000_0000);
    rd(OFF_STATUS, 32'h0000_0000);
    rd(OFF_MASK, 32'h0000_0000);
    rd(OFF_STATE, 32'h0000_0000);
    rd(8'h0C, 32'h0000_0000);
    check(32'(lastErr), 32'h0000_0001);
    wr(OFF_STATE, 32'h0000_00FF);
    rd(OFF_STATE, 32'h0000_0000);
    wr(OFF_MASK, 32'hFFFF_FFFF);
    rd(OFF_MASK, 32'h0000_000F);
  endtask
  task automatic t_write();
    wr(OFF_MASK, 32'h0000_0008);
    point(8'h20);
    iw(8'hA5, 1'b1);
    iw(8'h5A, 1'b1);
    iw(8'hC3, 1'b1);
    u_master.stop();
    rd(OFF_STATE, 32'h0000_0023);
    rd(OFF_STATUS, 32'h0000_0008);
    check(32'(irq), 32'h0000_0001);
    wr(OFF_STATUS, 32'h0000_0008);
    settle();
    check(32'(irq), 32'h0000_0000);
    wr(OFF_MASK, 32'h0000_0000);
  endtask
  task automatic t_read();
    point(8'h20);
    u_master.start();
    iw(8'hD1, 1'b1);
    ir(1'b1, 8'hA5);
    ir(1'b1, 8'h5A);
    ir(1'b0, 8'hC3);
    u_master.stop();
    point(8'h21);
    u_master.stop();
    rd(OFF_STATE, 32'h0000_0021);
    u_master.start();
    iw(8'hD1, 1'b1);
    ir(1'b0, 8'h5A);
    u_master.stop();
    u_master.start();
    iw(8'hA0, 1'b0);
    iw(8'hD0, 1'b0);
    u_master.stop();
  endtask
  task automatic t_freeze();
    logic [31:0] q;
    liveTime <= 64'h0807_0605_0403_0201;
    pulse();
    point(8'h00);
    st(q);
    check(32'(q[ST_FRZ]), 32'h0000_0001);
    liveTime <= 64'h1817_1615_1413_1211;
    pulse();
    u_master.start();
    iw(8'hD1, 1'b1);
    ir(1'b1, 8'h01);
    ir(1'b0, 8'h02);
    u_master.stop();
    settle();
    st(q);
    check(32'(q[ST_FRZ]), 32'h0000_0000);
    pulse();
    rdAt(8'h01, 8'h12);
  endtask
  task automatic t_tamper();
    logic [31:0] q;
    for (int k = 0; k < 2; k++) begin
      // Bit 0 of p is the polarity, bit 1 the connect mode; the idle pin level is their xor
      for (int p = 0; p < 4; p++) begin
        pin(k, p[0] ^ p[1]);
        point(TAMP1_ADDR + 8'(k));
        iw(8'h00, 1'b1);
        u_master.stop();
        point(TAMP1_ADDR + 8'(k));
        iw(8'(1 << TEB_BIT | (p / 2) << TCM_BIT | (p % 2) << TPM_BIT), 1'b1);
        u_master.stop();
        st(q);
        check(32'(q[ST_TB1 + k]), 32'h0000_0000);
        pin(k, !(p[0] ^ p[1]));
        settle();
        pin(k, p[0] ^ p[1]);
        settle();
        st(q);
        check(32'(q[ST_TB1 + k]), 32'h0000_0001);
        rd(OFF_STATUS, 32'(1 << (IRQ_TAMP1 + k)) | 32'h0000_0008);
        check(32'(irq), 32'h0000_0000);
        wr(OFF_STATUS, 32'h0000_000F);
      end
    end
  endtask
  task automatic t_power();
    logic [31:0] q;
    // The system chip enable passes through while supply is good
    extChipEnInN <= 1'b1;
    settle();
    check(32'(pwr), 32'h0000_000F);
    extChipEnInN <= 1'b0;
    settle();
    check(32'(pwr), 32'h0000_0007);
    powerFailIn <= 1'b1;
    settle();
    check(32'(pwr), 32'h0000_000D);
    st(q);
    check(32'(q[10:0]), 32'h0000_0100);
    rd(OFF_STATUS, 32'h0000_0004);
    u_master.start();
    iw(8'hD0, 1'b0);
    u_master.stop();
    batterySwitchIn <= 1'b1;
    settle();
    check(32'(extSramOe | rstOutOe), 32'h0000_0000);
    batterySwitchIn <= 1'b0;
    powerFailIn <= 1'b0;
    recoveryIn <= 1'b1;
    settle();
    check(32'(pwr), 32'h0000_000D);
    point(8'h00);
    iw(8'h77, 1'b1);
    u_master.stop();
    recoveryIn <= 1'b0;
    settle();
    check(32'(pwr), 32'h0000_0007);
    rdAt(8'h00, 8'h11);
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata, tamperInputOne, tamperInputTwo, powerFailIn,
     batterySwitchIn, recoveryIn, liveTime, liveUpdate, extChipEnInN} = '0;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    t_regs();
    t_write();
    t_read();
    t_freeze();
    t_tamper();
    t_power();
    tally_and_finish();
  end
  // The sequence needs roughly 13k cycles; over four times that means a hang
  initial begin
    repeat (60000) @(posedge clk_sys);
    nMismatch++;
    tally_and_finish();
  end
endmodule
